// ===== bench/adcs_analog_model.sv
// analog converter model answering conversion starts
`timescale 1ns/1ps
module adcs_analog_model #(
	parameter int DELAY = 3
) (
	input wire logic clk_i, // system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic start_i, // conversion start pulse
	input wire logic [4:0] sel_i, // selected positive input
	output logic done_o, // conversion finished pulse
	output logic [9:0] data_o // raw result
);
	int cnt;
	// result names its input; between results the data lines toggle
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= 0;
			done_o <= 1'b0;
			data_o <= 10'h155;
		end else begin
			done_o <= 1'b0;
			data_o <= ~data_o;
			if (start_i) begin
				cnt <= DELAY;
			end else if (cnt == 1) begin
				cnt <= 0;
				done_o <= 1'b1;
				data_o <= {5'h10, sel_i};
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : adcs_analog_model

// ===== bench/adcs_top_tb_top.sv
// self-checking bench for the converter sequence control
`timescale 1ns/1ps
module adcs_top_tb_top;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic timer_evt_i = 1'b0;
	logic cmu_evt_i = 1'b0;
	logic conv_done_i;
	logic [9:0] conv_data_i;
	logic sample_o, convert_start_o, ref_pos_ext_o, ref_neg_ext_o, irq_o;
	logic [4:0] ch0_pos_sel_o;
	logic [4:0] sel_log [64];
	int nlog = 0;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int b;
	logic [15:0] q;
	always #50 clk_i = ~clk_i;
	adcs_top u_dut (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i(4'h3), .avs_readdata_o, .avs_waitrequest_o,
		.timer_evt_i, .cmu_evt_i, .conv_done_i, .conv_data_i, .sample_o, .convert_start_o,
		.ch0_pos_sel_o, .ref_pos_ext_o, .ref_neg_ext_o, .irq_o);
	adcs_analog_model u_ana (.clk_i, .arst_n_i, .start_i(convert_start_o),
		.sel_i(ch0_pos_sel_o), .done_o(conv_done_i), .data_o(conv_data_i));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (convert_start_o === 1'b1) begin
			sel_log[nlog % 64] <= ch0_pos_sel_o;
			nlog <= nlog + 1;
		end
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// holds the request until waitrequest is seen low at a falling edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
		logic w;
		avs_address_i <= a;
		avs_writedata_i <= {16'h0, d};
		avs_read_i <= !wr;
		avs_write_i <= wr;
		// only the bench timeout ends a wait that never answers
		do begin
			@(negedge clk_i);
			w = avs_waitrequest_o;
			q = avs_readdata_o[15:0];
			@(posedge clk_i);
		end while (w !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic run(input logic [15:0] cb, input logic [4:0] e0, e1, e2);
		int base;
		int w;
		bus(1, 6'h01, cb);
		base = nlog;
		// sample-enable is only taken once the module is already on
		bus(1, 6'h00, 16'h80e4);
		bus(1, 6'h00, 16'h80e6);
		w = 0;
		while (nlog < base + 3 && w < 300) begin
			@(posedge clk_i);
			w++;
		end
		bus(1, 6'h00, 16'h0000);
		chk("sel0", {11'h0, sel_log[base % 64]}, {11'h0, e0});
		chk("sel1", {11'h0, sel_log[(base + 1) % 64]}, {11'h0, e1});
		chk("sel2", {11'h0, sel_log[(base + 2) % 64]}, {11'h0, e2});
	endtask : run
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		bus(0, 6'h00, 16'h0);
		chk("ctrl_a", q, 16'h0000);
		bus(1, 6'h01, 16'hefff);
		bus(0, 6'h01, 16'h0);
		chk("ctrl_b", q, 16'he47f);
		bus(0, 6'h10, 16'h0);
		chk("unmapped", q, 16'h0000);
		for (int r = 0; r < 8; r++) begin
			bus(1, 6'h01, 16'(r) << 13);
			@(negedge clk_i);
			chk("refs", {14'h0, ref_pos_ext_o, ref_neg_ext_o}, r[2] ? 16'h0 : {14'h0, r[0], r[1]});
			@(posedge clk_i);
		end
		bus(1, 6'h02, 16'h0200);
		bus(1, 6'h03, 16'h0503);
		bus(1, 6'h04, 16'h0006);
		bus(1, 6'h01, 16'h0000);
		bus(1, 6'h00, 16'h80e0);
		bus(1, 6'h00, 16'h80e2);
		b = 0;
		do begin
			bus(0, 6'h00, 16'h0);
			b++;
		end while (q[0] !== 1'b1 && b < 30);
		chk("done", q, 16'h80e1);
		// results read out before switching off
		bus(0, 6'h20, 16'h0);
		chk("buf0", q, 16'h0203);
		bus(1, 6'h00, 16'h8200);
		bus(0, 6'h20, 16'h0);
		chk("buf0 frac", q, 16'h80c0);
		bus(1, 6'h00, 16'h8100);
		bus(0, 6'h20, 16'h0);
		chk("buf0 sint", q, 16'h0003);
		b = nlog;
		bus(1, 6'h00, 16'h8002);
		bus(1, 6'h00, 16'h8000);
		repeat (8) @(posedge clk_i);
		chk("manual", 16'(nlog - b), 16'h0001);
		bus(1, 6'h00, 16'h0000);
		bus(0, 6'h20, 16'h0);
		chk("buf0 off", q, 16'h0000);
		run(16'h007d, 5'h03, 5'h05, 5'h03);
		run(16'h047c, 5'h01, 5'h02, 5'h01);
		bus(1, 6'h05, 16'h0003);
		bus(1, 6'h06, 16'h0001);
		bus(1, 6'h01, 16'h0004);
		b = nlog;
		bus(1, 6'h00, 16'h80e4);
		bus(1, 6'h00, 16'h80e6);
		for (int w = 0; w < 300 && irq_o !== 1'b1; w++) @(posedge clk_i);
		chk("seqs", 16'(nlog - b), 16'h0002);
		bus(1, 6'h00, 16'h0000);
		bus(1, 6'h06, 16'h0000);
		chk("irq masked", {15'h0, irq_o}, 16'h0000);
		bus(1, 6'h06, 16'h0001);
		chk("irq", {15'h0, irq_o}, 16'h0001);
		bus(1, 6'h05, 16'h0001);
		chk("irq cleared", {15'h0, irq_o}, 16'h0000);
		// split halves: one sequence per interrupt flips the filling half
		bus(1, 6'h01, 16'h0002);
		bus(1, 6'h00, 16'h80e0);
		bus(1, 6'h00, 16'h80e2);
		repeat (12) @(posedge clk_i);
		bus(0, 6'h01, 16'h0);
		chk("fill upper", q, 16'h0082);
		bus(1, 6'h00, 16'h80e2);
		repeat (12) @(posedge clk_i);
		bus(0, 6'h30, 16'h0);
		chk("upper half", q, 16'h0203);
		bus(0, 6'h21, 16'h0);
		chk("not flat", q, 16'h0000);
		bus(0, 6'h01, 16'h0);
		chk("fill lower", q, 16'h0002);
		bus(1, 6'h00, 16'h0000);
		for (int t = 0; t < 2; t++) begin
			bus(1, 6'h00, t ? 16'h80c0 : 16'h8080);
			bus(1, 6'h00, 16'h8002 | (t ? 16'h00c0 : 16'h0080));
			repeat (3) @(posedge clk_i);
			chk("sampling", {15'h0, sample_o}, 16'h0001);
			if (t) timer_evt_i <= 1'b1;
			else cmu_evt_i <= 1'b1;
			@(posedge clk_i);
			timer_evt_i <= 1'b0;
			cmu_evt_i <= 1'b0;
			repeat (2) @(posedge clk_i);
			chk("wrong event", {15'h0, sample_o}, 16'h0001);
			b = nlog;
			if (t) cmu_evt_i <= 1'b1;
			else timer_evt_i <= 1'b1;
			@(posedge clk_i);
			timer_evt_i <= 1'b0;
			cmu_evt_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			chk("started", 16'(nlog - b), 16'h0001);
			bus(1, 6'h00, 16'h0000);
		end
		print_verdict();
	end
endmodule : adcs_top_tb_top

// ===== hdl/adcs_pkg.sv
// constants and types shared by the converter sequence control
package adcs_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;
	localparam int unsigned RES_W = 10;
	localparam int unsigned BUF_DEPTH = 32;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned SCAN_W = 16;
	localparam int unsigned SCAN_IDX_W = 4;
	localparam int unsigned IRQ_W = 2;
	// ------------------------------------------------------------
	// register word indices (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL_A = 6'h00;
	localparam logic [5:0] IDX_CTRL_B = 6'h01;
	localparam logic [5:0] IDX_CTRL_C = 6'h02;
	localparam logic [5:0] IDX_INSEL = 6'h03;
	localparam logic [5:0] IDX_SCAN = 6'h04;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h05;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h06;
	localparam logic [5:0] IDX_BUF_BASE = 6'h20;
	// ------------------------------------------------------------
	// field positions and writable masks
	// ------------------------------------------------------------
	localparam int unsigned A_ON = 15;
	localparam int unsigned A_FMT = 8;
	localparam int unsigned A_TRIG = 5;
	localparam int unsigned A_ASTART = 2;
	localparam int unsigned A_SENA = 1;
	localparam int unsigned A_DONE = 0;
	localparam int unsigned B_REF = 13;
	localparam int unsigned B_SCAN = 10;
	localparam int unsigned B_FILL = 7;
	localparam int unsigned B_SEQ = 2;
	localparam int unsigned B_SPLIT = 1;
	localparam int unsigned B_ALT = 0;
	localparam int unsigned C_STIME = 8;
	localparam int unsigned C_DIV = 0;
	localparam int unsigned INSEL_A = 0;
	localparam int unsigned INSEL_B = 8;
	localparam logic [15:0] CTRL_A_WMASK = 16'ha3e4;
	localparam logic [15:0] CTRL_B_WMASK = 16'he47f;
	localparam logic [15:0] CTRL_C_WMASK = 16'h1fff;
	localparam logic [15:0] INSEL_WMASK = 16'h1f1f;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_TIMER = 3'h4;
	localparam logic [2:0] TRIG_CMU = 3'h6;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [2:0] REF_EXT_POS = 3'h1;
	localparam logic [2:0] REF_EXT_NEG = 3'h2;
	localparam logic [2:0] REF_EXT_BOTH = 3'h3;
	localparam logic [1:0] FMT_SINT = 2'h1;
	localparam logic [1:0] FMT_FRAC = 2'h2;
	localparam logic [1:0] FMT_SFRAC = 2'h3;
	localparam int unsigned IRQ_SEQ = 0;
	localparam int unsigned IRQ_DONE = 1;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b100
	} adcs_state_t;
endpackage : adcs_pkg

// ===== hdl/adcs_result_store.sv
// 32-word result store, emptied while the converter is off
`timescale 1ns/1ps
module adcs_result_store (
	input wire logic clk_i, // system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic clear_i, // wipe all words
	input wire logic wr_en_i, // store a result
	input wire logic [adcs_pkg::IDX_W-1:0] wr_idx_i, // word written
	input wire logic [adcs_pkg::RES_W-1:0] wr_data_i, // raw result
	input wire logic [adcs_pkg::IDX_W-1:0] rd_idx_i, // word read
	output logic [adcs_pkg::RES_W-1:0] rd_data_o // raw word
);
	logic [adcs_pkg::RES_W-1:0] mem [adcs_pkg::BUF_DEPTH];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < adcs_pkg::BUF_DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (clear_i) begin
			for (int i = 0; i < adcs_pkg::BUF_DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (wr_en_i) begin
			mem[wr_idx_i] <= wr_data_i;
		end
	end

	assign rd_data_o = mem[rd_idx_i];
endmodule : adcs_result_store

// ===== hdl/adcs_sticky_bit.sv
// one sticky event bit, set wins over clear
`timescale 1ns/1ps
module adcs_sticky_bit #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk_i, // system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic set_i, // event pulse
	input wire logic clr_i, // write-one-to-clear pulse
	output logic q_o // sticky state
);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_o <= RESET_VAL;
		end else if (set_i) begin
			q_o <= 1'b1;
		end else if (clr_i) begin
			q_o <= 1'b0;
		end
	end
endmodule : adcs_sticky_bit

// ===== hdl/adcs_top.sv
// converter sequence control with avalon-mm register slave
// Functional notes
// - reference code picks upper/lower references; 1xx acts like 000.
// - control b bits 12-11, 9-8 read zero and ignore writes.
// - scan enable steps mux a positive input through enabled scan inputs.
// - fill-half flag is read-only hardware state, meaningful in split mode.
// - fill-half 1 means converter fills words 10-1f, else 00-0f.
// - interrupt raised after every (n+1)th sample/convert sequence.
// - split mode: two 16-word halves; otherwise one 32-word buffer.
// - alternate mode: first sample mux a, then b and a alternate.
// - result buffer contents are dropped once module-on is cleared.
// - trigger 100 ends sampling on timer, 110 on measurement event.
// - auto-sample time spans 0 to 31 conversion clock periods.
`timescale 1ns/1ps
module adcs_top (
	input wire logic clk_i, // 10 mhz system clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic [adcs_pkg::ADDR_W-1:0] avs_address_i, // word index
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [adcs_pkg::DATA_W-1:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [adcs_pkg::DATA_W-1:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	input wire logic timer_evt_i, // timer compare pulse
	input wire logic cmu_evt_i, // measurement unit pulse
	input wire logic conv_done_i, // analog conversion finished
	input wire logic [adcs_pkg::RES_W-1:0] conv_data_i, // raw result
	output logic sample_o, // sample/hold tracking
	output logic convert_start_o, // start conversion pulse
	output logic [4:0] ch0_pos_sel_o, // positive input select
	output logic ref_pos_ext_o, // upper ref from external pin
	output logic ref_neg_ext_o, // lower ref from external pin
	output logic irq_o // level interrupt
);
	// ------------------------------------------------------------
	// registers and fields
	// ------------------------------------------------------------
	logic [15:0] ctrl_a, ctrl_b, ctrl_c, insel, scan_mask, irq_mask;
	logic sample_enable, conv_done_flag, fill_half_flag;
	logic [adcs_pkg::IRQ_W-1:0] irq_stat, irq_set, irq_clr;
	logic ack, wr_acc, end_sample, start_conv, conv_fin, seq_irq;
	logic use_b, cclk_tick, stime_hit;
	logic [7:0] div_cnt;
	logic [4:0] stime_cnt, seq_cnt, wr_off, buf_wr_idx, next_ch0_sel;
	logic [3:0] scan_pos;
	logic [15:0] wmask, reg_rd;
	logic [adcs_pkg::RES_W-1:0] buf_rd;
	adcs_pkg::adcs_state_t state, next_state;

	wire module_on = ctrl_a[adcs_pkg::A_ON];
	wire [1:0] out_format = ctrl_a[adcs_pkg::A_FMT +: 2];
	wire [2:0] trigger_source = ctrl_a[adcs_pkg::A_TRIG +: 3];
	wire auto_sample_start = ctrl_a[adcs_pkg::A_ASTART];
	wire [2:0] reference_select = ctrl_b[adcs_pkg::B_REF +: 3];
	wire scan_inputs_enable = ctrl_b[adcs_pkg::B_SCAN];
	wire [4:0] sequences_per_irq = ctrl_b[adcs_pkg::B_SEQ +: 5];
	wire split_buffer_mode = ctrl_b[adcs_pkg::B_SPLIT];
	wire alternate_mux_mode = ctrl_b[adcs_pkg::B_ALT];
	wire [4:0] auto_sample_time = ctrl_c[adcs_pkg::C_STIME +: 5];
	wire [7:0] clk_div = ctrl_c[adcs_pkg::C_DIV +: 8];
	wire [4:0] mux_a_sel = insel[adcs_pkg::INSEL_A +: 5];
	wire [4:0] mux_b_sel = insel[adcs_pkg::INSEL_B +: 5];

	// next enabled scan input after p, wrapping; p when none enabled
	function automatic logic [3:0] next_scan(input logic [15:0] m, input logic [3:0] p);
		logic [3:0] r;
		logic found;
		logic [3:0] k;
		r = p;
		found = 1'b0;
		for (int i = 1; i <= adcs_pkg::SCAN_W; i++) begin
			k = p + 4'(i);
			if (!found && m[k]) begin
				r = k;
				found = 1'b1;
			end
		end
		return r;
	endfunction : next_scan

	// ------------------------------------------------------------
	// avalon-mm slave, one wait cycle per access
	// ------------------------------------------------------------
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
	assign wr_acc = avs_write_i & ack;
	assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read_i | avs_write_i) & ~ack;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_a <= adcs_pkg::REG_RESET;
			ctrl_b <= adcs_pkg::REG_RESET;
			ctrl_c <= adcs_pkg::REG_RESET;
			insel <= adcs_pkg::REG_RESET;
			scan_mask <= adcs_pkg::REG_RESET;
			irq_mask <= adcs_pkg::REG_RESET;
		end else if (wr_acc) begin
			case (avs_address_i)
				adcs_pkg::IDX_CTRL_A: begin
					ctrl_a <= (ctrl_a & ~(wmask & adcs_pkg::CTRL_A_WMASK))
						| (avs_writedata_i[15:0] & wmask & adcs_pkg::CTRL_A_WMASK);
				end
				adcs_pkg::IDX_CTRL_B: begin
					ctrl_b <= (ctrl_b & ~(wmask & adcs_pkg::CTRL_B_WMASK))
						| (avs_writedata_i[15:0] & wmask & adcs_pkg::CTRL_B_WMASK);
				end
				adcs_pkg::IDX_CTRL_C: begin
					ctrl_c <= (ctrl_c & ~(wmask & adcs_pkg::CTRL_C_WMASK))
						| (avs_writedata_i[15:0] & wmask & adcs_pkg::CTRL_C_WMASK);
				end
				adcs_pkg::IDX_INSEL: begin
					insel <= (insel & ~(wmask & adcs_pkg::INSEL_WMASK))
						| (avs_writedata_i[15:0] & wmask & adcs_pkg::INSEL_WMASK);
				end
				adcs_pkg::IDX_SCAN: begin
					scan_mask <= (scan_mask & ~wmask) | (avs_writedata_i[15:0] & wmask);
				end
				adcs_pkg::IDX_IRQ_MASK: begin
					irq_mask <= (irq_mask & ~wmask) | (avs_writedata_i[15:0] & wmask);
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read path with output format
	// ------------------------------------------------------------
	always_comb begin
		reg_rd = '0;
		case (avs_address_i)
			adcs_pkg::IDX_CTRL_A: begin
				reg_rd = ctrl_a;
				reg_rd[adcs_pkg::A_SENA] = sample_enable;
				reg_rd[adcs_pkg::A_DONE] = conv_done_flag;
			end
			adcs_pkg::IDX_CTRL_B: begin
				reg_rd = ctrl_b;
				reg_rd[adcs_pkg::B_FILL] = fill_half_flag;
			end
			adcs_pkg::IDX_CTRL_C: reg_rd = ctrl_c;
			adcs_pkg::IDX_INSEL: reg_rd = insel;
			adcs_pkg::IDX_SCAN: reg_rd = scan_mask;
			adcs_pkg::IDX_IRQ_STAT: reg_rd = 16'(irq_stat);
			adcs_pkg::IDX_IRQ_MASK: reg_rd = irq_mask;
			default: begin
				if (avs_address_i >= adcs_pkg::IDX_BUF_BASE) begin
					case (out_format)
						adcs_pkg::FMT_SINT: reg_rd = {{7{~buf_rd[9]}}, buf_rd[8:0]};
						adcs_pkg::FMT_FRAC: reg_rd = {buf_rd, 6'h00};
						adcs_pkg::FMT_SFRAC: reg_rd = {~buf_rd[9], buf_rd[8:0], 6'h00};
						default: reg_rd = 16'(buf_rd);
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_readdata_o <= '0;
		end else if (avs_read_i && !ack) begin
			avs_readdata_o <= 32'(reg_rd);
		end
	end

	// ------------------------------------------------------------
	// sampling timer in conversion clock periods
	// ------------------------------------------------------------
	assign cclk_tick = (div_cnt == clk_div);
	assign stime_hit = (stime_cnt >= auto_sample_time);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt <= '0;
			stime_cnt <= '0;
		end else if (state != adcs_pkg::ST_SAMPLE) begin
			div_cnt <= '0;
			stime_cnt <= '0;
		end else if (cclk_tick) begin
			div_cnt <= '0;
			if (!stime_hit) begin
				stime_cnt <= stime_cnt + 5'h01;
			end
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// sample/convert sequencer
	// ------------------------------------------------------------
	// trigger selection
	always_comb begin
		case (trigger_source)
			adcs_pkg::TRIG_MANUAL: end_sample = ~sample_enable;
			adcs_pkg::TRIG_TIMER: end_sample = timer_evt_i;
			adcs_pkg::TRIG_CMU: end_sample = cmu_evt_i;
			adcs_pkg::TRIG_AUTO: end_sample = stime_hit;
			default: end_sample = 1'b0;
		endcase
	end

	assign start_conv = module_on && (state == adcs_pkg::ST_SAMPLE) && end_sample;
	assign conv_fin = module_on && (state == adcs_pkg::ST_CONVERT) && conv_done_i;
	assign seq_irq = conv_fin && (seq_cnt == sequences_per_irq);

	always_comb begin
		next_state = state;
		case (state)
			adcs_pkg::ST_IDLE: begin
				if (module_on && sample_enable) begin
					next_state = adcs_pkg::ST_SAMPLE;
				end
			end
			adcs_pkg::ST_SAMPLE: begin
				if (!module_on) begin
					next_state = adcs_pkg::ST_IDLE;
				end else if (end_sample) begin
					next_state = adcs_pkg::ST_CONVERT;
				end
			end
			adcs_pkg::ST_CONVERT: begin
				if (!module_on || conv_done_i) begin
					next_state = adcs_pkg::ST_IDLE;
				end
			end
			default: next_state = adcs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= adcs_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// hardware set/clear beats a software write in the same cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sample_enable <= 1'b0;
		end else if (!module_on) begin
			sample_enable <= 1'b0;
		end else if (conv_fin && auto_sample_start) begin
			sample_enable <= 1'b1;
		end else if (start_conv) begin
			sample_enable <= 1'b0;
		end else if (wr_acc && avs_address_i == adcs_pkg::IDX_CTRL_A && avs_byteenable_i[0]) begin
			sample_enable <= avs_writedata_i[adcs_pkg::A_SENA];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_done_flag <= 1'b0;
		end else if (conv_fin) begin
			conv_done_flag <= 1'b1;
		end else if (start_conv) begin
			conv_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			convert_start_o <= 1'b0;
		end else begin
			convert_start_o <= start_conv;
		end
	end
	assign sample_o = (state == adcs_pkg::ST_SAMPLE);

	// ------------------------------------------------------------
	// buffer pointer, sequence count, input selection
	// ------------------------------------------------------------
	// split halves follow the fill flag
	assign buf_wr_idx = split_buffer_mode ? {fill_half_flag, wr_off[3:0]} : wr_off;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_off <= '0;
			seq_cnt <= '0;
			fill_half_flag <= 1'b0;
		end else if (!module_on) begin
			wr_off <= '0;
			seq_cnt <= '0;
			fill_half_flag <= 1'b0;
		end else if (seq_irq) begin
			wr_off <= '0;
			seq_cnt <= '0;
			fill_half_flag <= split_buffer_mode ? ~fill_half_flag : 1'b0;
		end else if (conv_fin) begin
			wr_off <= wr_off + 5'h01;
			seq_cnt <= seq_cnt + 5'h01;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			use_b <= 1'b0;
			scan_pos <= '0;
		end else if (!module_on || seq_irq) begin
			use_b <= 1'b0;
			scan_pos <= next_scan(scan_mask, 4'hf);
		end else if (conv_fin) begin
			use_b <= alternate_mux_mode & ~use_b;
			if (!use_b) begin
				scan_pos <= next_scan(scan_mask, scan_pos);
			end
		end
	end

	always_comb begin
		if (use_b) begin
			next_ch0_sel = mux_b_sel;
		end else if (scan_inputs_enable) begin
			next_ch0_sel = {1'b0, scan_pos};
		end else begin
			next_ch0_sel = mux_a_sel;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ch0_pos_sel_o <= '0;
			ref_pos_ext_o <= 1'b0;
			ref_neg_ext_o <= 1'b0;
		end else begin
			ch0_pos_sel_o <= next_ch0_sel;
			ref_pos_ext_o <= (reference_select == adcs_pkg::REF_EXT_POS)
				|| (reference_select == adcs_pkg::REF_EXT_BOTH);
			ref_neg_ext_o <= (reference_select == adcs_pkg::REF_EXT_NEG)
				|| (reference_select == adcs_pkg::REF_EXT_BOTH);
		end
	end

	adcs_result_store u_store (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.clear_i(!module_on),
		.wr_en_i(conv_fin),
		.wr_idx_i(buf_wr_idx),
		.wr_data_i(conv_data_i),
		.rd_idx_i(avs_address_i[adcs_pkg::IDX_W-1:0]),
		.rd_data_o(buf_rd)
	);

	// ------------------------------------------------------------
	// interrupt status, write one to clear
	// ------------------------------------------------------------
	assign irq_set = {conv_fin, seq_irq};
	assign irq_clr = (wr_acc && avs_address_i == adcs_pkg::IDX_IRQ_STAT && avs_byteenable_i[0])
		? avs_writedata_i[adcs_pkg::IRQ_W-1:0] : '0;

	for (genvar g = 0; g < adcs_pkg::IRQ_W; g++) begin : g_irq
		adcs_sticky_bit #(.RESET_VAL(1'b0)) u_bit (
			.clk_i(clk_i),
			.arst_n_i(arst_n_i),
			.set_i(irq_set[g]),
			.clr_i(irq_clr[g]),
			.q_o(irq_stat[g])
		);
	end

	assign irq_o = |(irq_stat & irq_mask[adcs_pkg::IRQ_W-1:0]);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	chk_ref_decode: assert property (
		##1 ref_pos_ext_o == ($past(reference_select) == adcs_pkg::REF_EXT_POS
			|| $past(reference_select) == adcs_pkg::REF_EXT_BOTH))
		else $error("upper reference select wrong");
	chk_unimpl_zero: assert property (
		avs_read_i && !ack && avs_address_i == adcs_pkg::IDX_CTRL_B
		|=> avs_readdata_o[12:11] == 2'h0 && avs_readdata_o[9:8] == 2'h0)
		else $error("unimplemented control bits read nonzero");
	chk_split_half: assert property (
		conv_fin && split_buffer_mode
		|=> u_store.mem[{$past(fill_half_flag), $past(wr_off[3:0])}] == $past(conv_data_i))
		else $error("split write outside filling half");
	chk_seq_flip: assert property (
		seq_irq && split_buffer_mode |=> fill_half_flag != $past(fill_half_flag)
			&& irq_stat[adcs_pkg::IRQ_SEQ])
		else $error("sequence interrupt missed");
	chk_flat_wrap: assert property (
		conv_fin && !seq_irq && !split_buffer_mode |=> wr_off == $past(wr_off) + 5'h01)
		else $error("flat buffer pointer did not advance");
	chk_alt_first: assert property (
		conv_fin && alternate_mux_mode && !use_b && !seq_irq |=> use_b ##1 ch0_pos_sel_o == $past(mux_b_sel))
		else $error("alternate sample not on mux b");
	chk_off_clear: assert property (
		!module_on |=> state == adcs_pkg::ST_IDLE && wr_off == 5'h00 && !sample_enable)
		else $error("converter still active while off");
	chk_timer_end: assert property (
		module_on && state == adcs_pkg::ST_SAMPLE && trigger_source == adcs_pkg::TRIG_TIMER
		&& timer_evt_i |=> state == adcs_pkg::ST_CONVERT ##0 convert_start_o)
		else $error("timer event did not start conversion");
	chk_auto_restart: assert property (
		conv_fin && auto_sample_start |=> sample_enable)
		else $error("sampling not restarted");
	chk_done_clear: assert property (
		start_conv || (!conv_fin && !conv_done_flag) |=> !conv_done_flag)
		else $error("done bit set during conversion");
	chk_done_bound: assert property (
		conv_fin |=> conv_done_flag)
		else $error("done bit not set after conversion");

	cov_split_toggle: cover property (seq_irq && split_buffer_mode);
	cov_auto_cycle: cover property (conv_fin && auto_sample_start ##[1:40] start_conv);
	cov_alt_b: cover property (use_b && conv_fin);
endmodule : adcs_top
